// ===== core/pps_pkg.sv
// shared constants for both ends of the module power sequencing link
// assumes one 40 MHz clock on both ends; hold and ready-floor times are least times, all rounded up
package pps_pkg;

  // ************************************************
  // clock and time constants
  // ************************************************
  localparam longint unsigned CLK_HZ = 40_000_000;
  localparam longint unsigned ON_HOLD_MS = 1000; // key hold for power-on
  localparam longint unsigned OFF_HOLD_MS = 2500; // key hold for graceful off
  localparam longint unsigned EOFF_HOLD_MS = 200; // emergency-off hold
  localparam longint unsigned READY_MIN_MS = 20000; // earliest operational time
  localparam longint unsigned PMON_MS = 21000; // typical pad init done
  localparam longint unsigned SOFTWARE_READY_MS = 28000; // typical software ready
  localparam longint unsigned RESP_MS = 2000; // device answer latency
  localparam longint unsigned RESP_WAIT_MS = 6000; // host answer wait
  localparam longint unsigned FINAL_MS = 10000; // finalization before off
  localparam longint unsigned BOOT_TMO_MS = 40000; // host boot give-up time

  localparam longint unsigned ON_HOLD_CYC = (ON_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned OFF_HOLD_CYC = (OFF_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned EOFF_HOLD_CYC = (EOFF_HOLD_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned READY_MIN_CYC = (READY_MIN_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned PMON_CYC = (PMON_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned SOFTWARE_READY_CYC = (SOFTWARE_READY_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned RESP_CYC = (RESP_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned RESP_WAIT_CYC = (RESP_WAIT_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned FINAL_CYC = (FINAL_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned BOOT_TMO_CYC = (BOOT_TMO_MS * CLK_HZ + 999) / 1000;

  // ************************************************
  // command channel
  // ************************************************
  localparam logic [1:0] CMD_QUERY = 2'h0;
  localparam logic [1:0] SOFT_OFF_COMMAND = 2'h1;

  localparam int CNT_W = 32;

endpackage

// ===== core/pps_link_if.sv
// pins between the host controller and the module
// assumes both ends share one clock; open-collector lines resolve here
`timescale 1ns/1ps
interface pps_link_if;
  logic keyOut; // host drive level for the power key (always low)
  logic keyOe; // host pulls the power key
  logic powerKeyN; // resolved power key, pulled up inside the module
  logic emOut; // host drive level for emergency off
  logic emOe; // host pulls emergency off
  logic emergencyOffN; // resolved emergency off line
  logic powerMonitor; // pads configured
  logic softwareReady; // ready for commands
  logic cmdValid; // command strobe
  logic [1:0] cmdOp; // command code
  logic respValid; // answer strobe
  logic respOk; // answer status

  // open collector: released lines read high
  assign powerKeyN = keyOe ? keyOut : 1'b1;
  assign emergencyOffN = emOe ? emOut : 1'b1;

  modport device (
    input powerKeyN, emergencyOffN, cmdValid, cmdOp,
    output powerMonitor, softwareReady, respValid, respOk
  );
  modport host (
    output keyOut, keyOe, emOut, emOe, cmdValid, cmdOp,
    input powerMonitor, softwareReady, respValid, respOk
  );
endinterface

// ===== core/pps_host_end.sv
// host controller end: drives the power key and emergency off, waits for status
// assumes the module end sits on the same link interface and clock
`timescale 1ns/1ps
module pps_host_end
  import pps_pkg::*;
#(
  parameter int unsigned ON_HOLD = 32'(ON_HOLD_CYC),
  parameter int unsigned OFF_HOLD = 32'(OFF_HOLD_CYC),
  parameter int unsigned EOFF_HOLD = 32'(EOFF_HOLD_CYC),
  parameter int unsigned RESP_WAIT = 32'(RESP_WAIT_CYC),
  parameter int unsigned BOOT_TMO = 32'(BOOT_TMO_CYC)
) (
  input wire logic clock, // 40 MHz
  input wire logic rst_n, // async, active low
  pps_link_if.host link, // pins to the module
  input wire logic powerOnReq, // pulse: start the module
  input wire logic powerOffReq, // pulse: graceful key shutdown
  input wire logic emergencyReq, // pulse: unconditional shutdown
  input wire logic cmdReq, // pulse: send a command
  input wire logic [1:0] cmdCode, // command to send
  output logic busy, // not idle in off or on
  output logic moduleReady, // module seen ready
  output logic offConfirmed, // module seen powered off
  output logic bootTimeout, // ready never came
  output logic cmdDone, // pulse: command finished
  output logic cmdOk, // last answer status
  output logic cmdTimeout // last command got no answer
);

  typedef enum logic [2:0] {
    H_OFF, H_PRESS_ON, H_WAIT_RDY, H_ON, H_CMD, H_PRESS_OFF, H_WAIT_OFF, H_EMERG
  } pps_host_state_t;

  typedef struct packed {
    pps_host_state_t state;
    logic [CNT_W-1:0] cnt;
    logic keyOe;
    logic emOe;
    logic cmdValid;
    logic [1:0] cmdOp;
    logic ready;
    logic offOk;
    logic bootTmo;
    logic done;
    logic ok;
    logic tmo;
    logic bsy;
  } pps_host_st_t;

  pps_host_st_t r_reg;
  pps_host_st_t r_next;

  // ************************************************
  // sequencing
  // ************************************************
  always_comb begin
    r_next = r_reg;
    r_next.cmdValid = 1'b0;
    r_next.done = 1'b0;
    r_next.cnt = r_reg.cnt + 32'h1;
    if (emergencyReq && r_reg.state != H_EMERG) begin
      r_next.state = H_EMERG;
      r_next.emOe = 1'b1;
      r_next.keyOe = 1'b0;
      r_next.cnt = '0;
    end else begin
      case (r_reg.state)
        H_OFF: begin
          if (powerOnReq) begin
            r_next.state = H_PRESS_ON;
            r_next.keyOe = 1'b1;
            r_next.bootTmo = 1'b0;
            r_next.offOk = 1'b0;
            r_next.cnt = '0;
          end
        end
        H_PRESS_ON: begin
          // hold exactly ON_HOLD cycles, then release
          if (r_reg.cnt >= ON_HOLD - 1) begin
            r_next.keyOe = 1'b0;
            r_next.state = H_WAIT_RDY;
            r_next.cnt = '0;
          end
        end
        H_WAIT_RDY: begin
          if (link.softwareReady) begin
            r_next.state = H_ON;
            r_next.ready = 1'b1;
          end else if (r_reg.cnt >= BOOT_TMO) begin
            r_next.state = H_OFF;
            r_next.bootTmo = 1'b1;
          end
        end
        H_ON: begin
          if (!link.softwareReady) begin
            r_next.state = H_WAIT_OFF;
          end else if (powerOffReq) begin
            r_next.state = H_PRESS_OFF;
            r_next.keyOe = 1'b1;
            r_next.cnt = '0;
          end else if (cmdReq) begin
            r_next.state = H_CMD;
            r_next.cmdValid = 1'b1;
            r_next.cmdOp = cmdCode;
            r_next.tmo = 1'b0;
            r_next.cnt = '0;
          end
        end
        H_CMD: begin
          // a soft off gets no answer; the status lines tell the story
          if (r_reg.cmdOp == SOFT_OFF_COMMAND) begin
            r_next.state = H_WAIT_OFF;
            r_next.done = 1'b1;
            r_next.ok = 1'b1;
          end else if (link.respValid) begin
            r_next.state = H_ON;
            r_next.done = 1'b1;
            r_next.ok = link.respOk;
          end else if (r_reg.cnt >= RESP_WAIT - 1) begin
            r_next.state = H_ON;
            r_next.done = 1'b1;
            r_next.ok = 1'b0;
            r_next.tmo = 1'b1;
          end
        end
        H_PRESS_OFF: begin
          if (r_reg.cnt >= OFF_HOLD - 1) begin
            r_next.keyOe = 1'b0;
            r_next.state = H_WAIT_OFF;
          end
        end
        H_EMERG: begin
          if (r_reg.cnt >= EOFF_HOLD - 1) begin
            r_next.emOe = 1'b0;
            r_next.state = H_WAIT_OFF;
          end
        end
        H_WAIT_OFF: begin
          if (!link.powerMonitor && !link.softwareReady) begin
            r_next.state = H_OFF;
            r_next.ready = 1'b0;
            r_next.offOk = 1'b1;
          end
        end
        default: r_next.state = H_OFF;
      endcase
    end
    // busy kept as a flip-flop so the output carries no decode glitch
    r_next.bsy = (r_next.state != H_OFF) && (r_next.state != H_ON);
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: H_OFF, cmdOp: CMD_QUERY, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.keyOut = 1'b0;
  assign link.keyOe = r_reg.keyOe;
  assign link.emOut = 1'b0;
  assign link.emOe = r_reg.emOe;
  assign link.cmdValid = r_reg.cmdValid;
  assign link.cmdOp = r_reg.cmdOp;
  assign busy = r_reg.bsy;
  assign moduleReady = r_reg.ready;
  assign offConfirmed = r_reg.offOk;
  assign bootTimeout = r_reg.bootTmo;
  assign cmdDone = r_reg.done;
  assign cmdOk = r_reg.ok;
  assign cmdTimeout = r_reg.tmo;

endmodule

// ===== core/pps_device_end.sv
// module end: power-on, boot status and the three shutdown paths
// assumes inputs synchronous to clock; supply loss acts as a full reset
//
// How it works
// - host holds key low one second
// - boot runs, no host access meanwhile
// - operational no sooner than twenty seconds
// - commands ignored during initialization
// - host waits for activation before talking
// - software ready rises when commands accepted
// - power monitor rises when pads configured
// - key tied low boots on supply
// - host only pulls key low
// - host waits up to six seconds
// - soft command, key, emergency shut down
// - graceful paths detach first, emergency skips
// - both status lines low when off
// - host holds key 2.5 s to stop
// - host holds emergency off 200 ms
`timescale 1ns/1ps
module pps_device_end
  import pps_pkg::*;
#(
  parameter int unsigned ON_HOLD = 32'(ON_HOLD_CYC),
  parameter int unsigned OFF_HOLD = 32'(OFF_HOLD_CYC),
  parameter int unsigned EOFF_HOLD = 32'(EOFF_HOLD_CYC),
  parameter int unsigned READY_MIN = 32'(READY_MIN_CYC),
  parameter int unsigned PMON_AT = 32'(PMON_CYC),
  parameter int unsigned SOFTWARE_READY_AT = 32'(SOFTWARE_READY_CYC),
  parameter int unsigned RESP_LAT = 32'(RESP_CYC),
  parameter int unsigned FINAL_LEN = 32'(FINAL_CYC)
) (
  input wire logic clock, // 40 MHz
  input wire logic rst_n, // async, active low
  pps_link_if.device link, // pins from the host
  input wire logic batterySupply, // supply present
  output logic detachReq, // pulse: detach from network
  output logic poweredOn, // level: not in off state
  output logic finalizing // level: shutdown in progress
);

  // four power states; commands only matter in ready
  typedef enum logic [1:0] {
    D_OFF, D_BOOT, D_READY, D_FINAL
  } pps_dev_state_t;

  typedef struct packed {
    pps_dev_state_t state;
    logic [CNT_W-1:0] keyCnt;
    logic [CNT_W-1:0] emCnt;
    logic [CNT_W-1:0] tmr;
    logic [CNT_W-1:0] rspCnt;
    logic rspBusy;
    logic rspOk;
    logic respValid;
    logic pmon;
    logic srdy;
    logic detach;
    logic supplyPrev;
    logic on; // registered copy of state not off
    logic fin; // registered copy of state finalizing
  } pps_dev_st_t;

  // ready may not come before the floor, whatever the typical value
  localparam int unsigned RDY_EFF = (SOFTWARE_READY_AT < READY_MIN) ? READY_MIN : SOFTWARE_READY_AT;

  // whole state in one record: one comb fill, one register
  pps_dev_st_t r_reg;
  pps_dev_st_t r_next;

  // saturating count so a key tied low never wraps
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 32'h1;
  endfunction

  // a key release judged against a hold threshold, for power-on and key shutdown
  function automatic logic held_for(input logic rel, input logic [CNT_W-1:0] cnt,
    input int unsigned thr);
    held_for = rel && (cnt >= thr);
  endfunction

  // qualified pin levels, shared by every state
  logic keyLow;
  logic keyRel;
  logic emLow;

  // ************************************************
  // pin qualification
  // ************************************************
  // no debounce: inputs are taken as synchronous and already clean
  // the hold length stands in keyCnt on the cycle the key comes back high
  assign keyLow = !link.powerKeyN;
  assign keyRel = !keyLow && (r_reg.keyCnt != '0);
  assign emLow = !link.emergencyOffN;

  // ************************************************
  // sequencing
  // ************************************************
  always_comb begin
    r_next = r_reg;
    r_next.detach = 1'b0;
    r_next.respValid = 1'b0;
    r_next.supplyPrev = batterySupply;
    r_next.keyCnt = keyLow ? sat_inc(r_reg.keyCnt) : '0;
    r_next.emCnt = emLow ? sat_inc(r_reg.emCnt) : '0;
    r_next.tmr = sat_inc(r_reg.tmr);
    if (!batterySupply) begin
      // no supply: everything drops, nothing is remembered
      r_next = '{state: D_OFF, default: '0};
    end else if (r_reg.state != D_OFF && r_reg.emCnt >= EOFF_HOLD) begin
      // unconditional path: straight off, no detach
      // acts while still held, so a line stuck low keeps the module down
      r_next.state = D_OFF;
      r_next.pmon = 1'b0;
      r_next.srdy = 1'b0;
      r_next.rspBusy = 1'b0;
    end else begin
      case (r_reg.state)
        D_OFF: begin
          // supply edge with the key already low is the tied-key boot
          if (!r_reg.supplyPrev && keyLow) begin
            r_next.state = D_BOOT;
            r_next.tmr = '0;
          end else if (held_for(keyRel, r_reg.keyCnt, ON_HOLD)) begin
            // boot time counts from the key going low
            r_next.state = D_BOOT;
            r_next.tmr = r_reg.keyCnt;
          end
          // shorter pulses fall through and leave the state alone
        end
        D_BOOT: begin
          // commands are not looked at while booting
          if (r_reg.tmr >= PMON_AT) begin
            r_next.pmon = 1'b1;
          end
          if (r_reg.tmr >= RDY_EFF) begin
            r_next.srdy = 1'b1;
            r_next.state = D_READY;
          end
        end
        D_READY: begin
          if (r_reg.rspBusy) begin
            r_next.rspCnt = sat_inc(r_reg.rspCnt);
            if (r_reg.rspCnt >= RESP_LAT - 1) begin
              r_next.respValid = 1'b1;
              r_next.rspBusy = 1'b0;
            end
          end
          // a key shutdown drops any answer still being counted, except one falling due this cycle
          if (held_for(keyRel, r_reg.keyCnt, OFF_HOLD)) begin
            r_next.state = D_FINAL;
            r_next.detach = 1'b1;
            r_next.rspBusy = 1'b0;
            r_next.tmr = '0;
          end else if (link.cmdValid && !r_reg.rspBusy) begin
            if (link.cmdOp == SOFT_OFF_COMMAND) begin
              r_next.state = D_FINAL;
              r_next.detach = 1'b1;
              r_next.tmr = '0;
            end else begin
              // one command in flight; a second strobe while busy is dropped
              r_next.rspBusy = 1'b1;
              r_next.rspCnt = '0;
              r_next.rspOk = (link.cmdOp == CMD_QUERY);
            end
          end
        end
        D_FINAL: begin
          // key and commands are ignored while finalizing
          // fixed length here; hosts must still watch the status lines, not a timer
          if (r_reg.tmr >= FINAL_LEN - 1) begin
            r_next.state = D_OFF;
            r_next.pmon = 1'b0;
            r_next.srdy = 1'b0;
          end
        end
        default: r_next.state = D_OFF;
      endcase
    end
    // status flags follow the next state so they leave the same flip-flop edge
    r_next.on = (r_next.state != D_OFF);
    r_next.fin = (r_next.state == D_FINAL);
  end

  // ************************************************
  // state register
  // ************************************************
  // supply loss is handled above, so rst_n is only the power-up clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: D_OFF, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************
  // outputs, all from r_reg
  // ************************************************
  assign link.powerMonitor = r_reg.pmon;
  assign link.softwareReady = r_reg.srdy;
  assign link.respValid = r_reg.respValid;
  assign link.respOk = r_reg.rspOk;
  assign detachReq = r_reg.detach;
  // registered copies rather than state decodes, so no decode glitch leaves the block
  assign poweredOn = r_reg.on;
  assign finalizing = r_reg.fin;

endmodule

// ===== bench/pps_link_properties.sv
// concurrent checks on the pins between host end and module end
// assumes one clock; the bench instantiates it beside the first link
`timescale 1ns/1ps
module pps_link_properties
  import pps_pkg::*;
#(
  parameter int ON_HOLD = 4,
  parameter int EOFF_HOLD = 3,
  parameter int READY_MIN = 40,
  parameter int RESP_LAT = 5
) (
  input wire logic clock, // link clock
  input wire logic rst_n, // async, active low
  input wire logic keyOut, // host key drive level
  input wire logic keyOe, // host pulls the key
  input wire logic powerKeyN, // resolved key
  input wire logic emergencyOffN, // resolved emergency off
  input wire logic powerMonitor, // pads configured
  input wire logic softwareReady, // ready for commands
  input wire logic cmdValid, // command strobe
  input wire logic [1:0] cmdOp, // command code
  input wire logic respValid // answer strobe
);
  localparam int RESP_DLY = RESP_LAT + 1;
  logic [7:0] keyLowCnt;
  logic [7:0] emLowCnt;
  logic [7:0] sinceKey;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ************
  // helper counters
  // ************
  // saturating, so a long idle stretch never wraps into a short count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      keyLowCnt <= 8'h00;
      emLowCnt <= 8'h00;
      sinceKey <= 8'hFF;
    end else begin
      keyLowCnt <= powerKeyN ? 8'h00 : keyLowCnt + {7'h00, keyLowCnt != 8'hFF};
      emLowCnt <= emergencyOffN ? 8'h00 : emLowCnt + {7'h00, emLowCnt != 8'hFF};
      sinceKey <= (!powerKeyN && keyLowCnt == 8'h00) ? 8'h00 :
                  sinceKey + {7'h00, sinceKey != 8'hFF};
    end
  end

  // ************
  // properties
  // ************
  sequence s_em_held;
    !emergencyOffN [*4];
  endsequence
  sequence s_status_off;
    !powerMonitor && !softwareReady;
  endsequence

  a_key_pull_only: assert property (keyOe |-> !keyOut)
    else $error("key driven high");
  a_on_hold_min: assert property ($rose(powerKeyN) |-> int'(keyLowCnt) >= ON_HOLD)
    else $error("key press too short");
  a_emerg_hold_min: assert property ($rose(emergencyOffN) |-> int'(emLowCnt) >= EOFF_HOLD)
    else $error("emergency press too short");
  a_emerg_off_fast: assert property (s_em_held |-> ##[1:2] s_status_off)
    else $error("emergency off not acted on");
  a_ready_min_time: assert property ($rose(softwareReady) |-> int'(sinceKey) >= READY_MIN)
    else $error("ready too early");
  a_ready_after_pmon: assert property (softwareReady |-> powerMonitor)
    else $error("ready without pads configured");
  a_off_both_low: assert property ($fell(powerMonitor) || $fell(softwareReady) |-> s_status_off)
    else $error("status lines fell apart");
  a_resp_latency: assert property (cmdValid && softwareReady && cmdOp != SOFT_OFF_COMMAND
    |-> ##RESP_DLY respValid)
    else $error("answer late or missing");
  a_resp_has_cmd: assert property (respValid |-> softwareReady && $past(cmdValid, RESP_DLY))
    else $error("answer without accepted command");
endmodule

// ===== bench/module_power_on_off_sequencer_test.sv
// bench: host end and module end on one link, and a second module end whose
// link is driven straight by the bench for short presses and misuse
// assumes shortened counts below and one 40 MHz clock
`timescale 1ns/1ps
module module_power_on_off_sequencer_test;
  import pps_pkg::*;
  localparam int PMON_AT = 30;
  localparam int SOFTWARE_READY_AT = 50;
  localparam int KEY_ON = 4; // device thresholds, shortened
  localparam int KEY_OFF = 10;
  localparam int EM_HOLD = 3;
  localparam int RDY_MIN = 40;
  localparam int RESP = 5;
  localparam int FIN = 20;
  localparam int WAIT_RESP = 12; // host answer wait
  localparam int BOOT_GIVEUP = 100; // host boot give-up
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bat1 = 1'b0; // starts without supply for the boot give-up case
  logic bat2 = 1'b1;
  logic [3:0] req = 4'h0; // on, off, emergency, command
  logic [1:0] cmdCode = 2'h0;
  logic busy, modReady, offConf, bootTmo, cmdDone, cmdOk, cmdTmo, det1, on1, on2, fin1;
  logic [1:0] codes [3] = '{2'h0, 2'h2, 2'h3};
  int errTotal = 0;
  int nChecks = 0;
  int detCnt = 0;
  int finCnt = 0;
  int resp2Cnt = 0;
  wire [3:0] flags = {modReady, offConf, bootTmo, cmdDone};

  pps_link_if link1();
  pps_link_if link2();

  always #12.5 clock = ~clock;

  // pulses counted off the edge so the count never races the register
  always @(negedge clock) begin
    detCnt += (det1 === 1'b1);
    finCnt += (fin1 === 1'b1);
    resp2Cnt += (link2.respValid === 1'b1);
  end

  // host holds sit one cycle above the device thresholds
  pps_host_end #(.ON_HOLD(KEY_ON + 1), .OFF_HOLD(KEY_OFF + 1), .EOFF_HOLD(EM_HOLD + 1),
    .RESP_WAIT(WAIT_RESP), .BOOT_TMO(BOOT_GIVEUP))
    pps_host_end_i (.clock(clock), .rst_n(rst_n), .link(link1), .powerOnReq(req[3]),
    .powerOffReq(req[2]), .emergencyReq(req[1]), .cmdReq(req[0]), .cmdCode(cmdCode),
    .busy(busy), .moduleReady(modReady), .offConfirmed(offConf), .bootTimeout(bootTmo),
    .cmdDone(cmdDone), .cmdOk(cmdOk), .cmdTimeout(cmdTmo));
  pps_device_end #(.ON_HOLD(KEY_ON), .OFF_HOLD(KEY_OFF), .EOFF_HOLD(EM_HOLD),
    .READY_MIN(RDY_MIN), .PMON_AT(PMON_AT), .SOFTWARE_READY_AT(SOFTWARE_READY_AT), .RESP_LAT(RESP),
    .FINAL_LEN(FIN)) pps_device_end_i (.clock(clock),
    .rst_n(rst_n), .link(link1), .batterySupply(bat1), .detachReq(det1), .poweredOn(on1),
    .finalizing(fin1));
  pps_device_end #(.ON_HOLD(KEY_ON), .OFF_HOLD(KEY_OFF), .EOFF_HOLD(EM_HOLD),
    .READY_MIN(RDY_MIN), .PMON_AT(PMON_AT), .SOFTWARE_READY_AT(SOFTWARE_READY_AT), .RESP_LAT(RESP),
    .FINAL_LEN(FIN)) pps_device_end_i2 (.clock(clock),
    .rst_n(rst_n), .link(link2), .batterySupply(bat2), .detachReq(), .poweredOn(on2),
    .finalizing());
  pps_link_properties #(.ON_HOLD(KEY_ON), .EOFF_HOLD(EM_HOLD), .READY_MIN(RDY_MIN),
    .RESP_LAT(RESP)) pps_link_properties_i (.clock(clock), .rst_n(rst_n),
    .keyOut(link1.keyOut), .keyOe(link1.keyOe), .powerKeyN(link1.powerKeyN),
    .emergencyOffN(link1.emergencyOffN), .powerMonitor(link1.powerMonitor),
    .softwareReady(link1.softwareReady), .cmdValid(link1.cmdValid), .cmdOp(link1.cmdOp),
    .respValid(link1.respValid));

  // ************
  // tasks
  // ************
  task automatic chk(input string nm, input logic exp, input logic got);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic waitFlag(input int sel, input int lim);
    for (int i = 0; i < lim && flags[sel] !== 1'b1; i++) step(1);
  endtask
  task automatic hostReq(input logic [3:0] w, input logic [1:0] c);
    @(posedge clock);
    req <= w;
    cmdCode <= c;
    @(posedge clock);
    req <= 4'h0;
    #1;
  endtask
  // boot times are counted from the first cycle the key reads low
  task automatic bootUp();
    int t = 0;
    int pmAt = 0;
    hostReq(4'h8, 2'h0);
    for (int i = 0; i < 9 && link1.powerKeyN !== 1'b0; i++) step(1);
    while (t < 200 && link1.softwareReady !== 1'b1) begin
      step(1);
      t++;
      if (link1.powerMonitor === 1'b1 && pmAt == 0) pmAt = t;
    end
    chk("pmon time", 1'b1, pmAt >= PMON_AT && pmAt <= PMON_AT + 3);
    chk("ready time", 1'b1, t >= SOFTWARE_READY_AT && t <= SOFTWARE_READY_AT + 3);
    waitFlag(3, 5);
    chk("module ready", 1'b1, modReady);
  endtask
  task automatic shutDown(input logic [3:0] w, input logic [1:0] c, input logic detExp);
    int det0;
    int fin0;
    det0 = detCnt;
    fin0 = finCnt;
    hostReq(w, c);
    waitFlag(2, 120);
    chk("off confirmed", 1'b1, offConf);
    chk("status low", 1'b0, link1.powerMonitor | link1.softwareReady | on1);
    chk("detach", detExp, detCnt != det0);
    chk("finalizing", detExp, finCnt != fin0);
  endtask
  task automatic press2(input int n);
    @(posedge clock);
    link2.keyOe <= 1'b1;
    repeat (n) @(posedge clock);
    link2.keyOe <= 1'b0;
    step(1);
  endtask
  task automatic conclude();
    if (errTotal == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************
  // test sequence
  // ************
  initial begin
    {link2.keyOut, link2.keyOe, link2.emOut, link2.emOe} = 4'h0;
    link2.cmdValid = 1'b0;
    link2.cmdOp = 2'h0;
    step(8);
    rst_n <= 1'b1;
    step(1);
    chk("idle", 1'b0, busy | link1.powerMonitor | link1.softwareReady | ~link1.powerKeyN);
    hostReq(4'h8, 2'h0);
    waitFlag(1, 150);
    chk("boot timeout", 1'b1, bootTmo);
    bat1 <= 1'b1;
    bootUp();
    foreach (codes[i]) begin
      hostReq(4'h1, codes[i]);
      waitFlag(0, 20);
      chk("cmd done", 1'b1, cmdDone);
      chk("cmd ok", codes[i] == CMD_QUERY, cmdOk);
      chk("cmd timeout", 1'b0, cmdTmo);
    end
    shutDown(4'h4, 2'h0, 1'b1);
    bootUp();
    shutDown(4'h1, SOFT_OFF_COMMAND, 1'b1);
    bootUp();
    shutDown(4'h2, 2'h0, 1'b0);
    // one low sample short of the threshold, then exactly on it
    press2(3);
    step(60);
    chk("short press", 1'b0, on2 | link2.powerMonitor);
    press2(4);
    chk("exact press", 1'b1, on2);
    @(posedge clock);
    link2.cmdValid <= 1'b1;
    @(posedge clock);
    link2.cmdValid <= 1'b0;
    step(12);
    chk("no answer in boot", 1'b1, resp2Cnt == 0);
    bat2 <= 1'b0;
    link2.keyOe <= 1'b1;
    step(3);
    chk("supply loss", 1'b0, on2 | link2.powerMonitor | link2.softwareReady);
    bat2 <= 1'b1;
    step(3);
    chk("tied key boot", 1'b1, on2);
    conclude();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    errTotal++;
    conclude();
  end
endmodule
